// ==== hdl/rcsd_regs.sv ====
// Sleep measurement, wake interrupt timing, diagnostic ports and error flags
// Overview of operation
// - Clear sleep count at start, count lp ticks
// - External wake holds irq for hold cycles
// - Assert irq assert-lead cycles before timer expiry
// - Clear irq clear-lead cycles before timer expiry
// - Ten-bit read/write fine phase correction
// - Twenty-seven-bit read/write base time correction
// - Disabled diagnostic port drives all zeros
// - Enabled port shows selected internal signal group
// - Readback returns four live debug buses
// - Sixteen-bit read/write debug zone upper limit
// - Sixteen-bit read/write debug zone lower limit
// - Flag bit 11 on invalid format
// - Flag bit 10 on null transmit pointer
// - Flag bit 8 on late memory access
// - Flag bit 7 on channel count mismatch
// - Zero sleep target means unlimited sleep
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "rcsd_params.svh"

module rcsd_regs
  import rcsd_pkg::*;
#(
  parameter int LP_DIV = `RCSD_LP_DIV,
  parameter int CHMAP_W = 37,
  parameter int TXPTR_W = 14
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [31:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic sleep_request_i,
  input wire logic ext_wake_i,
  input wire logic [31:0] sleep_length_target_i,
  output logic sleep_active_o,
  output logic lowpower_wake_irq_o,
  output logic [9:0] fine_count_correction_o,
  output logic [26:0] base_count_correction_o,
  output logic [15:0] zone_upper_limit_o,
  output logic [15:0] zone_lower_limit_o,
  input wire logic [63:0][7:0] diag_sources_i,
  output logic [3:0][7:0] debug_bus_o,
  input wire logic format_invalid_i,
  input wire logic cs_fetch_i,
  input wire logic [TXPTR_W-1:0] control_structure_tx_pointer_i,
  input wire logic radio_memory_late_i,
  input wire logic hop_start_i,
  input wire logic [CHMAP_W-1:0] channel_use_map_i,
  input wire logic [5:0] good_channel_count_i
);

  logic ack_reg;
  logic access;
  logic take;
  logic [31:0] wmask;
  logic [31:0] sleep_length_count_reg;
  rcsd_wake_timing_t wake_timing_reg;
  logic [9:0] fine_corr_reg;
  logic [26:0] base_corr_reg;
  rcsd_diag_ctrl_t [3:0] diag_ctrl_reg;
  logic [15:0] zone_upper_reg;
  logic [15:0] zone_lower_reg;
  logic [31:0] err_flags_reg;
  logic [31:0] err_flags_next;
  logic [31:0] rdata_next;
  logic [31:0] readdata_reg;
  logic [1:0] sleep_req_sync_reg;
  logic [1:0] ext_wake_sync_reg;
  logic sleep_req_prev_reg;
  logic [$clog2(LP_DIV+1)-1:0] lp_div_reg;
  logic lp_tick;
  rcsd_sleep_state_t state_reg;
  logic [10:0] hold_count_reg;
  logic irq_reg;
  logic [31:0] remaining;
  logic [6:0] ones_count;
  logic sleep_start;
  logic wake_seen;
  logic timed_tick;
  logic assert_hit;
  logic clear_hit;
  logic expiry_hit;
  logic hold_done;

  // One-cycle wait state; the request is taken at the edge with waitrequest low
  assign access = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = access & ~ack_reg;
  assign take = access & ack_reg;
  assign avs_readdata_o = readdata_reg;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= access & ~ack_reg;
    end
  end

  // Byte-lane write mask
  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_lane
      assign wmask[8*b +: 8] = {8{avs_byteenable_i[b]}};
    end
  endgenerate

  // Read mux; unmapped addresses read zero and ignore writes
  always_comb begin
    rdata_next = `RCSD_RESET_VALUE;
    case (avs_address_i)
      `RCSD_OFS_SLEEP_LEN: rdata_next = sleep_length_count_reg;
      `RCSD_OFS_WAKE_TIMING: rdata_next = wake_timing_reg;
      `RCSD_OFS_FINE_CORR: rdata_next = {22'h000000, fine_corr_reg};
      `RCSD_OFS_BASE_CORR: rdata_next = {5'h00, base_corr_reg};
      `RCSD_OFS_DIAG_CTRL: rdata_next = {diag_ctrl_reg[3] & 8'hbf, diag_ctrl_reg[2] & 8'hbf,
                                         diag_ctrl_reg[1] & 8'hbf, diag_ctrl_reg[0] & 8'hbf};
      `RCSD_OFS_DIAG_READ: rdata_next = debug_bus_o;
      `RCSD_OFS_ZONE_UPPER: rdata_next = {16'h0000, zone_upper_reg};
      `RCSD_OFS_ZONE_LOWER: rdata_next = {16'h0000, zone_lower_reg};
      `RCSD_OFS_ERR_FLAGS: rdata_next = err_flags_reg;
      default: rdata_next = `RCSD_RESET_VALUE;
    endcase
  end

  // Captured in the wait state so read data stand when waitrequest drops
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      readdata_reg <= `RCSD_RESET_VALUE;
    end else if (avs_read_i && !ack_reg) begin
      readdata_reg <= rdata_next;
    end
  end

  // Software-written registers
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      wake_timing_reg <= `RCSD_RESET_VALUE;
      fine_corr_reg <= 10'h000;
      base_corr_reg <= 27'h0000000;
      diag_ctrl_reg <= `RCSD_RESET_VALUE;
      zone_upper_reg <= 16'h0000;
      zone_lower_reg <= 16'h0000;
    end else if (take && avs_write_i) begin
      case (avs_address_i)
        `RCSD_OFS_WAKE_TIMING: begin
          wake_timing_reg <= (wake_timing_reg & ~wmask) | (avs_writedata_i & wmask);
        end
        `RCSD_OFS_FINE_CORR: begin
          fine_corr_reg <= (fine_corr_reg & ~wmask[9:0]) | (avs_writedata_i[9:0] & wmask[9:0]);
        end
        `RCSD_OFS_BASE_CORR: begin
          base_corr_reg <= (base_corr_reg & ~wmask[26:0]) | (avs_writedata_i[26:0] & wmask[26:0]);
        end
        `RCSD_OFS_DIAG_CTRL: begin
          diag_ctrl_reg <= (diag_ctrl_reg & ~wmask) | (avs_writedata_i & wmask & 32'hbfbf_bfbf);
        end
        `RCSD_OFS_ZONE_UPPER: begin
          zone_upper_reg <= (zone_upper_reg & ~wmask[15:0]) | (avs_writedata_i[15:0] & wmask[15:0]);
        end
        `RCSD_OFS_ZONE_LOWER: begin
          zone_lower_reg <= (zone_lower_reg & ~wmask[15:0]) | (avs_writedata_i[15:0] & wmask[15:0]);
        end
        default: begin
        end
      endcase
    end
  end

  assign fine_count_correction_o = fine_corr_reg;
  assign base_count_correction_o = base_corr_reg;
  assign zone_upper_limit_o = zone_upper_reg;
  assign zone_lower_limit_o = zone_lower_reg;

  // Diagnostic ports, registered so the readback matches the pins exactly
  genvar p;
  generate
    for (p = 0; p < 4; p++) begin : g_diag
      always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
          debug_bus_o[p] <= 8'h00;
        end else if (diag_ctrl_reg[p].enable) begin
          debug_bus_o[p] <= diag_sources_i[diag_ctrl_reg[p].select];
        end else begin
          debug_bus_o[p] <= 8'h00;
        end
      end
    end
  endgenerate

  // Pin synchronisers
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      sleep_req_sync_reg <= 2'b00;
      ext_wake_sync_reg <= 2'b00;
      sleep_req_prev_reg <= 1'b0;
    end else begin
      sleep_req_sync_reg <= {sleep_req_sync_reg[0], sleep_request_i};
      ext_wake_sync_reg <= {ext_wake_sync_reg[0], ext_wake_i};
      sleep_req_prev_reg <= sleep_req_sync_reg[1];
    end
  end

  // Low-power clock as an enable pulse from a divider
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      lp_div_reg <= '0;
    end else if (lp_tick) begin
      lp_div_reg <= '0;
    end else begin
      lp_div_reg <= lp_div_reg + 1'b1;
    end
  end

  assign lp_tick = (lp_div_reg == ($clog2(LP_DIV+1))'(LP_DIV - 1));

  // Cycles left before the sleep timer expires
  assign remaining = sleep_length_target_i - sleep_length_count_reg;
  // Rising edge of the synchronised request opens a phase
  assign sleep_start = sleep_req_sync_reg[1] & ~sleep_req_prev_reg;
  assign wake_seen = ext_wake_sync_reg[1];

  // Zero target never expires; only a wake request ends the phase
  assign timed_tick = lp_tick & (sleep_length_target_i != 32'h0000_0000);
  assign assert_hit = timed_tick & (remaining == {21'h000000, wake_timing_reg.assert_lead} + 32'h0000_0001);
  assign clear_hit = timed_tick & (remaining == {22'h000000, wake_timing_reg.clear_lead} + 32'h0000_0001);
  assign expiry_hit = timed_tick & (remaining == 32'h0000_0001);
  // Relies on software keeping hold above the clear lead; zero acts like one
  assign hold_done = lp_tick & (hold_count_reg + 11'h001 >= wake_timing_reg.hold);

  // Sleep phase sequencing
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state_reg <= RCSD_ACTIVE;
      hold_count_reg <= 11'h000;
    end else begin
      case (state_reg)
        RCSD_ACTIVE: begin
          if (sleep_start) begin
            state_reg <= RCSD_SLEEP;
          end
        end
        RCSD_SLEEP: begin
          // A tick on the wake edge is dropped; the hold counts whole ticks after it
          if (wake_seen) begin
            state_reg <= RCSD_EXT_HOLD;
            hold_count_reg <= 11'h000;
          end else if (expiry_hit) begin
            state_reg <= RCSD_ACTIVE;
          end
        end
        RCSD_EXT_HOLD: begin
          if (hold_done) begin
            state_reg <= RCSD_ACTIVE;
          end else if (lp_tick) begin
            hold_count_reg <= hold_count_reg + 11'h001;
          end
        end
        default: begin
          state_reg <= RCSD_ACTIVE;
        end
      endcase
    end
  end

  // Count is left alone outside sleep so software can read the last phase
  // A wake request freezes it at the wake instant
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      sleep_length_count_reg <= 32'h0000_0000;
    end else if (state_reg == RCSD_ACTIVE && sleep_start) begin
      sleep_length_count_reg <= 32'h0000_0000;
    end else if (state_reg == RCSD_SLEEP && !wake_seen && lp_tick) begin
      sleep_length_count_reg <= sleep_length_count_reg + 32'h0000_0001;
    end
  end

  // Wake interrupt; a clear lead hit beats an assert lead hit in one tick
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      irq_reg <= 1'b0;
    end else if (state_reg == RCSD_ACTIVE && sleep_start) begin
      irq_reg <= 1'b0;
    end else if (state_reg == RCSD_SLEEP && wake_seen) begin
      irq_reg <= 1'b1;
    end else if (state_reg == RCSD_SLEEP && clear_hit) begin
      irq_reg <= 1'b0;
    end else if (state_reg == RCSD_SLEEP && assert_hit) begin
      irq_reg <= 1'b1;
    end else if (state_reg == RCSD_EXT_HOLD && hold_done) begin
      irq_reg <= 1'b0;
    end
  end

  assign sleep_active_o = (state_reg == RCSD_SLEEP);
  assign lowpower_wake_irq_o = irq_reg;

  // Ones in the channel use map
  always_comb begin
    ones_count = 7'h00;
    for (int i = 0; i < CHMAP_W; i++) begin
      ones_count = ones_count + {6'h00, channel_use_map_i[i]};
    end
  end

  // Sticky error flags, cleared by a read; a new event beats the clear
  always_comb begin
    err_flags_next = err_flags_reg;
    // Clear only what the read returned, so a flag raised in the wait state survives
    if (take && avs_read_i && avs_address_i == `RCSD_OFS_ERR_FLAGS) begin
      err_flags_next = err_flags_reg & ~readdata_reg;
    end
    if (format_invalid_i) begin
      err_flags_next[`RCSD_ERR_FORMAT_BIT] = 1'b1;
    end
    if (cs_fetch_i && control_structure_tx_pointer_i == '0) begin
      err_flags_next[`RCSD_ERR_TXPTR_BIT] = 1'b1;
    end
    if (radio_memory_late_i) begin
      err_flags_next[`RCSD_ERR_RADIO_MEM_BIT] = 1'b1;
    end
    if (hop_start_i && ones_count != {1'b0, good_channel_count_i}) begin
      err_flags_next[`RCSD_ERR_CHMAP_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      err_flags_reg <= `RCSD_RESET_VALUE;
    end else begin
      err_flags_reg <= err_flags_next;
    end
  end

endmodule // rcsd_regs

// ==== hdl/rcsd_params.svh ====
// Register map, field positions, reset values and timing counts
`ifndef RCSD_PARAMS_SVH
`define RCSD_PARAMS_SVH

`define RCSD_OFS_SLEEP_LEN 32'h4000_0038
`define RCSD_OFS_WAKE_TIMING 32'h4000_003c
`define RCSD_OFS_FINE_CORR 32'h4000_0040
`define RCSD_OFS_BASE_CORR 32'h4000_0044
`define RCSD_OFS_DIAG_CTRL 32'h4000_0050
`define RCSD_OFS_DIAG_READ 32'h4000_0054
`define RCSD_OFS_ZONE_UPPER 32'h4000_0058
`define RCSD_OFS_ZONE_LOWER 32'h4000_005c
`define RCSD_OFS_ERR_FLAGS 32'h4000_0060

`define RCSD_FINE_CORR_W 10
`define RCSD_BASE_CORR_W 27
`define RCSD_ZONE_W 16
`define RCSD_HOLD_W 11
`define RCSD_ASSERT_W 11
`define RCSD_CLEAR_W 10

`define RCSD_ERR_FORMAT_BIT 11
`define RCSD_ERR_TXPTR_BIT 10
`define RCSD_ERR_RADIO_MEM_BIT 8
`define RCSD_ERR_CHMAP_BIT 7

`define RCSD_RESET_VALUE 32'h0000_0000

`define RCSD_SYS_CLK_HZ 50000000
`define RCSD_LP_CLK_HZ 32768
`define RCSD_LP_DIV (`RCSD_SYS_CLK_HZ / `RCSD_LP_CLK_HZ)

`endif

// ==== hdl/rcsd_pkg.sv ====
// Types shared by the sleep and diagnostic register block
package rcsd_pkg;

  typedef struct packed {
    logic [10:0] hold;
    logic [10:0] assert_lead;
    logic [9:0] clear_lead;
  } rcsd_wake_timing_t;

  typedef struct packed {
    logic enable;
    logic reserved;
    logic [5:0] select;
  } rcsd_diag_ctrl_t;

  typedef enum logic [1:0] {
    RCSD_ACTIVE,
    RCSD_SLEEP,
    RCSD_EXT_HOLD
  } rcsd_sleep_state_t;

endpackage

// ==== verif/rcsd_regs_asserts.sv ====
// Port-level checker for the sleep and diagnostic register block
`timescale 1ns/1ps
`include "rcsd_params.svh"
module rcsd_regs_asserts (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [31:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic sleep_active_o,
  input wire logic ext_wake_i,
  input wire logic [31:0] sleep_length_target_i,
  input wire logic lowpower_wake_irq_o,
  input wire logic [9:0] fine_count_correction_o,
  input wire logic [26:0] base_count_correction_o,
  input wire logic [15:0] zone_upper_limit_o,
  input wire logic [15:0] zone_lower_limit_o,
  input wire logic [3:0][7:0] debug_bus_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic wr;
  logic rd;
  // Full-word writes only, so the whole field is known
  assign wr = avs_write_i && !avs_waitrequest_o && avs_byteenable_i == 4'hf;
  assign rd = avs_read_i && !avs_waitrequest_o;
  AST_FINE: assert property (wr && avs_address_i == `RCSD_OFS_FINE_CORR |=>
    fine_count_correction_o == $past(avs_writedata_i[9:0])) else $error("fine correction not stored");
  AST_BASE: assert property (wr && avs_address_i == `RCSD_OFS_BASE_CORR |=>
    base_count_correction_o == $past(avs_writedata_i[26:0])) else $error("base correction not stored");
  AST_UPPER: assert property (wr && avs_address_i == `RCSD_OFS_ZONE_UPPER |=>
    zone_upper_limit_o == $past(avs_writedata_i[15:0])) else $error("upper limit not stored");
  AST_LOWER: assert property (wr && avs_address_i == `RCSD_OFS_ZONE_LOWER |=>
    zone_lower_limit_o == $past(avs_writedata_i[15:0])) else $error("lower limit not stored");
  AST_READBACK: assert property (rd && avs_address_i == `RCSD_OFS_DIAG_READ |->
    avs_readdata_o == $past(debug_bus_o)) else $error("readback differs");
  AST_ERR_RSVD: assert property (rd && avs_address_i == `RCSD_OFS_ERR_FLAGS |->
    avs_readdata_o[31:12] == 20'h0 && !avs_readdata_o[9] && avs_readdata_o[6:0] == 7'h0)
    else $error("error flags reserved bits set");
  AST_WAKE: assert property ($rose(ext_wake_i) && sleep_active_o |-> ##[2:5] lowpower_wake_irq_o)
    else $error("external wake gave no interrupt");
  AST_IRQ_SLEEP: assert property ($rose(lowpower_wake_irq_o) |-> $past(sleep_active_o))
    else $error("interrupt rose outside sleep");
  // Synchroniser delay: ext wake must have been low for three samples
  AST_UNLIMITED: assert property (sleep_active_o && sleep_length_target_i == 32'h0 && !ext_wake_i &&
    !$past(ext_wake_i) && !$past(ext_wake_i, 2) |=> sleep_active_o) else $error("unlimited sleep ended");
  cover property (wr);
  cover property ($fell(lowpower_wake_irq_o));
  cover property (rd && avs_address_i == `RCSD_OFS_ERR_FLAGS && avs_readdata_o != 32'h0);
endmodule // rcsd_regs_asserts

bind rcsd_regs rcsd_regs_asserts u_rcsd_regs_asserts (.clk_i, .rst_b_i, .avs_address_i, .avs_read_i,
  .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .sleep_active_o,
  .ext_wake_i, .sleep_length_target_i, .lowpower_wake_irq_o, .fine_count_correction_o,
  .base_count_correction_o, .zone_upper_limit_o, .zone_lower_limit_o, .debug_bus_o);

// ==== verif/rcsd_regs_test.sv ====
// Self-checking bench for the sleep and diagnostic register block
`timescale 1ns/1ps
`include "rcsd_params.svh"
module rcsd_regs_test;
  import rcsd_pkg::*;
  localparam int DIV = 4;
  logic clk_i, rst_b_i, avs_read_i, avs_write_i, avs_waitrequest_o, sleep_request_i, ext_wake_i;
  logic sleep_active_o, lowpower_wake_irq_o, format_invalid_i, cs_fetch_i, radio_memory_late_i, hop_start_i;
  logic [31:0] avs_address_i, avs_writedata_i, avs_readdata_o, sleep_length_target_i, rd, e;
  logic [3:0] avs_byteenable_i;
  logic [9:0] fine_count_correction_o;
  logic [26:0] base_count_correction_o;
  logic [15:0] zone_upper_limit_o, zone_lower_limit_o;
  logic [63:0][7:0] diag_sources_i;
  logic [3:0][7:0] debug_bus_o;
  logic [13:0] control_structure_tx_pointer_i;
  logic [36:0] channel_use_map_i;
  logic [5:0] good_channel_count_i;
  int failures, num_checks, cycles, n, hi;
  // Lead values kept as software must: hold and assert above clear
  rcsd_wake_timing_t wt = '{hold: 11'h2, assert_lead: 11'h3, clear_lead: 10'h1};
  logic [31:0] ofs [9] = '{`RCSD_OFS_SLEEP_LEN, `RCSD_OFS_WAKE_TIMING, `RCSD_OFS_FINE_CORR,
    `RCSD_OFS_BASE_CORR, `RCSD_OFS_DIAG_CTRL, `RCSD_OFS_ZONE_UPPER, `RCSD_OFS_ZONE_LOWER,
    `RCSD_OFS_ERR_FLAGS, 32'h4000_0048};
  logic [31:0] msk [9] = '{32'h0, 32'hffff_ffff, 32'h3ff, 32'h7ff_ffff, 32'hbfbf_bfbf, 32'hffff,
    32'hffff, 32'h0, 32'h0};

  rcsd_regs #(.LP_DIV(DIV)) u_rcsd_regs (.clk_i, .rst_b_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .sleep_request_i, .ext_wake_i,
    .sleep_length_target_i, .sleep_active_o, .lowpower_wake_irq_o, .fine_count_correction_o,
    .base_count_correction_o, .zone_upper_limit_o, .zone_lower_limit_o, .diag_sources_i, .debug_bus_o,
    .format_invalid_i, .cs_fetch_i, .control_structure_tx_pointer_i, .radio_memory_late_i, .hop_start_i,
    .channel_use_map_i, .good_channel_count_i);

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic stop_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      stop_test();
    end
  end

  task automatic check(input string nm, input logic [31:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Request held until waitrequest is sampled low, then an idle cycle
  task automatic bus(input logic wr, input logic [31:0] a, d);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rchk(input string nm, input logic [31:0] a, exp);
    bus(1'b0, a, 32'h0);
    check(nm, exp, rd);
  endtask

  task automatic pulse(input logic [3:0] p);
    {format_invalid_i, cs_fetch_i, radio_memory_late_i, hop_start_i} <= p;
    @(posedge clk_i);
    {format_invalid_i, cs_fetch_i, radio_memory_late_i, hop_start_i} <= 4'h0;
    @(posedge clk_i);
  endtask

  task automatic wait_sleep(input logic v);
    n = 0;
    while (sleep_active_o !== v && n < 40) begin
      @(posedge clk_i);
      n++;
    end
  endtask

  initial begin
    {rst_b_i, avs_read_i, avs_write_i, sleep_request_i, ext_wake_i} = 5'h0;
    {format_invalid_i, cs_fetch_i, radio_memory_late_i, hop_start_i} = 4'h0;
    {avs_address_i, avs_writedata_i, sleep_length_target_i} = 96'h0;
    {control_structure_tx_pointer_i, channel_use_map_i, good_channel_count_i} = 57'h0;
    avs_byteenable_i = 4'hf;
    for (int k = 0; k < 64; k++) diag_sources_i[k] = 8'(k) ^ 8'h5a;
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    rchk("readback reset", `RCSD_OFS_DIAG_READ, 32'h0);
    for (int k = 0; k < 9; k++) rchk("reset value", ofs[k], 32'h0);
    for (int k = 0; k < 9; k++) bus(1'b1, ofs[k], 32'hffff_ffff);
    for (int k = 0; k < 9; k++) rchk("access mask", ofs[k], msk[k]);
    check("fine pin", 32'h3ff, 32'(fine_count_correction_o));
    check("base pin", 32'h7ff_ffff, 32'(base_count_correction_o));
    check("upper pin", 32'hffff, 32'(zone_upper_limit_o));
    check("lower pin", 32'hffff, 32'(zone_lower_limit_o));
    avs_byteenable_i <= 4'h1;
    bus(1'b1, `RCSD_OFS_ZONE_UPPER, 32'h0000_a5c3);
    avs_byteenable_i <= 4'hf;
    rchk("lane mask", `RCSD_OFS_ZONE_UPPER, 32'hffc3);
    $display("test registers done");
    // Port 2 disabled with a nonzero selector
    bus(1'b1, `RCSD_OFS_DIAG_CTRL, 32'hbf11_aa83);
    // Ports follow the control one clock after the write lands
    @(posedge clk_i);
    e = {8'd63 ^ 8'h5a, 8'h00, 8'd42 ^ 8'h5a, 8'd3 ^ 8'h5a};
    check("debug bus", e, debug_bus_o);
    rchk("readback", `RCSD_OFS_DIAG_READ, e);
    diag_sources_i[3] <= 8'h11;
    repeat (2) @(posedge clk_i);
    rchk("live readback", `RCSD_OFS_DIAG_READ, {e[31:8], 8'h11});
    $display("test diagnostic done");
    pulse(4'h8);
    rchk("format flag", `RCSD_OFS_ERR_FLAGS, 32'h800);
    rchk("flags clear", `RCSD_OFS_ERR_FLAGS, 32'h0);
    control_structure_tx_pointer_i <= 14'h123;
    pulse(4'h4);
    rchk("pointer valid", `RCSD_OFS_ERR_FLAGS, 32'h0);
    control_structure_tx_pointer_i <= 14'h0;
    pulse(4'h4);
    rchk("pointer null", `RCSD_OFS_ERR_FLAGS, 32'h400);
    pulse(4'h2);
    rchk("memory late", `RCSD_OFS_ERR_FLAGS, 32'h100);
    channel_use_map_i <= 37'h10_0000_0003;
    good_channel_count_i <= 6'h3;
    pulse(4'h1);
    rchk("map match", `RCSD_OFS_ERR_FLAGS, 32'h0);
    good_channel_count_i <= 6'h4;
    pulse(4'h1);
    rchk("map mismatch", `RCSD_OFS_ERR_FLAGS, 32'h80);
    $display("test error flags done");
    bus(1'b1, `RCSD_OFS_WAKE_TIMING, 32'(wt));
    sleep_length_target_i <= 32'h8;
    sleep_request_i <= 1'b1;
    wait_sleep(1'b1);
    hi = 0;
    n = 0;
    // Interrupt spans from count T-3 to T-1: two ticks
    while (sleep_active_o === 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
      hi += (lowpower_wake_irq_o === 1'b1);
    end
    check("irq window", 2 * DIV, hi);
    rchk("sleep length", `RCSD_OFS_SLEEP_LEN, 32'h8);
    repeat (20) @(posedge clk_i);
    rchk("length kept", `RCSD_OFS_SLEEP_LEN, 32'h8);
    $display("test timed sleep done");
    sleep_length_target_i <= 32'h0;
    sleep_request_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    sleep_request_i <= 1'b1;
    wait_sleep(1'b1);
    repeat (40) @(posedge clk_i);
    check("unlimited sleep", 1'b1, sleep_active_o);
    ext_wake_i <= 1'b1;
    hi = 0;
    n = 0;
    while (hi == 0 || lowpower_wake_irq_o === 1'b1) begin
      @(posedge clk_i);
      n++;
      hi += (lowpower_wake_irq_o === 1'b1);
      if (n > 100) break;
    end
    ext_wake_i <= 1'b0;
    check("hold ticks", 1'b1, hi > DIV && hi <= 2 * DIV);
    bus(1'b0, `RCSD_OFS_SLEEP_LEN, 32'h0);
    check("wake length", 1'b1, rd >= 32'd9 && rd <= 32'd11);
    $display("test external wake done");
    stop_test();
  end
endmodule // rcsd_regs_test
